// ### nsl_pace.sv
// Constants, carrier types and the flash pacing timer of the status lamp driver.
// Assumes one free-running system clock and a synchronous active-high reset.
`timescale 1ns/100ps

// ----------------------------------------------------------------------------
// Package
// ----------------------------------------------------------------------------
package nsl_pkg;
  localparam int unsigned CLK_KHZ = 250000;
  localparam int unsigned FLASH_HALF_MS = 500;
  localparam int unsigned GROUP_PAUSE_MS = 2000;
  localparam int unsigned FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;
  localparam int unsigned PACE_W = 27;
  localparam int unsigned PAUSE_TICKS = GROUP_PAUSE_MS / FLASH_HALF_MS;
  localparam int unsigned MAX_CONN = 5;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;
  localparam logic [3:0] CONFIG_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] FLASH_ADDR = 4'h8;
  localparam logic [3:0] LAMP_ADDR = 4'hC;
  localparam int unsigned PROTO_W = 2;
  localparam int unsigned STATUS_W = 15;
  localparam int unsigned FLASH_OK_BIT = 0;
  localparam int unsigned FLASH_FAIL_BIT = 1;
  localparam int unsigned LAMP_INFO_W = 8;

  typedef enum logic [1:0] {
    PROTO_EIP = 2'h0,
    PROTO_MBT = 2'h1,
    PROTO_PNT = 2'h2
  } nsl_proto_type;

  typedef enum logic [2:0] {
    MODE_OFF = 3'h0,
    MODE_GREEN = 3'h1,
    MODE_RED = 3'h2,
    MODE_FLASH_G = 3'h3,
    MODE_FLASH_R = 3'h4,
    MODE_ALT = 3'h5,
    MODE_GROUP = 3'h6
  } nsl_mode_type;

  typedef enum logic [2:0] {
    GRP_ON = 3'b001,
    GRP_OFF = 3'b010,
    GRP_PAUSE = 3'b100
  } nsl_grp_type;

  // Conditions reported by the adapter firmware
  typedef struct packed {
    logic [2:0] conn_count;
    logic io_run;
    logic io_conn;
    logic dup_ip;
    logic conn_timeout;
    logic implicit_conn;
    logic ip_set;
    logic name_set;
    logic addr_changed;
    logic net_ok;
    logic drive_ok;
    logic link_up;
    logic selftest_done;
  } nsl_status_type;

  typedef struct packed {
    logic red;
    logic green;
  } nsl_lamp_type;
endpackage

// ----------------------------------------------------------------------------
// Pacing timer: one tick per flash half period
// ----------------------------------------------------------------------------
module nsl_pace #(
  parameter int unsigned HALF_CYCLES = nsl_pkg::FLASH_HALF_CYCLES
) (
  input wire logic clk_i,   // System clock
  input wire logic rst_i,   // Synchronous reset
  output logic tick_o,      // One-cycle pulse per half period
  output logic phase_o      // Toggles on every tick
);
  logic [nsl_pkg::PACE_W-1:0] cnt_q;
  logic [nsl_pkg::PACE_W-1:0] cnt_d;
  logic wrap;

  assign wrap = (cnt_q == nsl_pkg::PACE_W'(HALF_CYCLES - 1));
  assign cnt_d = wrap ? '0 : cnt_q + nsl_pkg::PACE_W'(1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      tick_o <= 1'b0;
      phase_o <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_o <= wrap;
      phase_o <= phase_o ^ wrap;
    end
  end
endmodule

// ### nsl_led_top.sv
// Module and network status lamp driver for a networked servo drive.
// Assumes firmware reports conditions through the register port; lamps
// are driven directly by the four colour outputs.
`timescale 1ns/100ps

module nsl_led_top #(
  parameter int unsigned FLASH_HALF_CYCLES = nsl_pkg::FLASH_HALF_CYCLES
) (
  input wire logic CLOCK_I,                        // 250 MHz system clock
  input wire logic RESET_I,                        // Sync reset, active high
  input wire logic [nsl_pkg::ADDR_W-1:0] ADDR_I,   // Register byte address
  input wire logic [nsl_pkg::DATA_W-1:0] WDATA_I,  // Write data
  input wire logic WR_I,                           // Write strobe
  input wire logic RD_I,                           // Read strobe
  output logic [nsl_pkg::DATA_W-1:0] RDATA_O,      // Read data, next cycle
  output logic MS_RED_O,                           // Module lamp red
  output logic MS_GREEN_O,                         // Module lamp green
  output logic NS_RED_O,                           // Link lamp red
  output logic NS_GREEN_O                          // Link lamp green
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  nsl_pkg::nsl_proto_type proto_q;
  nsl_pkg::nsl_status_type st_q;
  nsl_pkg::nsl_mode_type ms_mode_d, ms_mode_q, ns_mode_d, ns_mode_q, pnt_ms, pnt_ns;
  nsl_pkg::nsl_mode_type eip_ns, mbt_ns, proto_ns, proto_ms;
  nsl_pkg::nsl_grp_type grp_d, grp_q;
  nsl_pkg::nsl_lamp_type ms_lamp, ns_lamp;
  logic [2:0] fl_d, fl_q, pz_d, pz_q, conn_n;
  logic locked_q, fail_q, tick, phase, grp_run;
  logic wr_cfg, wr_st, wr_flash, flash_ok_ev, flash_fail_ev;
  logic [nsl_pkg::DATA_W-1:0] rd_mux;

  // --------------------------------------------------------------------------
  // Lamp drive
  // --------------------------------------------------------------------------
  function automatic nsl_pkg::nsl_lamp_type lamp_drive(
    input nsl_pkg::nsl_mode_type mode, input logic ph, input logic grp_on);
    nsl_pkg::nsl_lamp_type l;
    l = '0;
    case (mode)
      nsl_pkg::MODE_GREEN: l.green = 1'b1;
      nsl_pkg::MODE_RED: l.red = 1'b1;
      nsl_pkg::MODE_FLASH_G: l.green = ph;
      nsl_pkg::MODE_FLASH_R: l.red = ph;
      nsl_pkg::MODE_ALT: begin
        l.red = ph;
        l.green = !ph;
      end
      nsl_pkg::MODE_GROUP: l.green = grp_on;
      default: l = '0;
    endcase
    return l;
  endfunction

  nsl_pace #(
    .HALF_CYCLES(FLASH_HALF_CYCLES)
  ) u_pace (
    .clk_i(CLOCK_I),
    .rst_i(RESET_I),
    .tick_o(tick),
    .phase_o(phase)
  );

  // --------------------------------------------------------------------------
  // Register port
  // --------------------------------------------------------------------------
  assign wr_cfg = WR_I && (ADDR_I == nsl_pkg::CONFIG_ADDR) && !locked_q;
  assign wr_st = WR_I && (ADDR_I == nsl_pkg::STATUS_ADDR);
  assign wr_flash = WR_I && (ADDR_I == nsl_pkg::FLASH_ADDR) && !locked_q;
  assign flash_ok_ev = wr_flash && WDATA_I[nsl_pkg::FLASH_OK_BIT];
  assign flash_fail_ev = wr_flash && WDATA_I[nsl_pkg::FLASH_FAIL_BIT];

  assign rd_mux =
    (ADDR_I == nsl_pkg::CONFIG_ADDR) ? nsl_pkg::DATA_W'(proto_q) :
    (ADDR_I == nsl_pkg::STATUS_ADDR) ? nsl_pkg::DATA_W'(st_q) :
    (ADDR_I == nsl_pkg::FLASH_ADDR) ? nsl_pkg::DATA_W'({fail_q, locked_q}) :
    (ADDR_I == nsl_pkg::LAMP_ADDR) ?
      nsl_pkg::DATA_W'({ns_lamp, ms_lamp, 1'b0, ns_mode_q, ms_mode_q}) :
    '0;

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      proto_q <= nsl_pkg::PROTO_EIP;
      st_q <= '0;
      locked_q <= 1'b0;
      fail_q <= 1'b0;
      RDATA_O <= '0;
    end else begin
      if (wr_cfg) begin
        proto_q <= nsl_pkg::nsl_proto_type'(WDATA_I[nsl_pkg::PROTO_W-1:0]);
      end
      if (wr_st) begin
        st_q <= nsl_pkg::nsl_status_type'(WDATA_I[nsl_pkg::STATUS_W-1:0]);
      end
      locked_q <= locked_q | flash_ok_ev;
      fail_q <= fail_q | flash_fail_ev;
      RDATA_O <= RD_I ? rd_mux : '0;
    end
  end

  // --------------------------------------------------------------------------
  // Module lamp selection
  // --------------------------------------------------------------------------
  assign pnt_ms = (st_q.name_set && st_q.ip_set) ? nsl_pkg::MODE_GREEN :
                  nsl_pkg::MODE_FLASH_G;
  assign proto_ms =
    (proto_q == nsl_pkg::PROTO_PNT) ? pnt_ms :
    !st_q.link_up ? nsl_pkg::MODE_FLASH_G :
    (st_q.drive_ok && st_q.net_ok) ? nsl_pkg::MODE_GREEN :
    nsl_pkg::MODE_FLASH_G;
  assign ms_mode_d =
    !st_q.selftest_done ? nsl_pkg::MODE_ALT :
    (fail_q || st_q.addr_changed) ? nsl_pkg::MODE_FLASH_R :
    locked_q ? nsl_pkg::MODE_FLASH_G :
    proto_ms;

  // --------------------------------------------------------------------------
  // Link lamp selection
  // --------------------------------------------------------------------------
  // Counts above the supported five are shown as five
  assign conn_n = (st_q.conn_count > 3'(nsl_pkg::MAX_CONN)) ?
                  3'(nsl_pkg::MAX_CONN) : st_q.conn_count;
  assign eip_ns =
    st_q.dup_ip ? nsl_pkg::MODE_RED :
    (st_q.conn_timeout && ms_mode_d == nsl_pkg::MODE_GREEN) ?
      nsl_pkg::MODE_FLASH_R :
    st_q.implicit_conn ? nsl_pkg::MODE_GREEN :
    st_q.link_up ? nsl_pkg::MODE_FLASH_G :
    nsl_pkg::MODE_OFF;
  assign mbt_ns = (conn_n == 3'h0 || !st_q.link_up) ? nsl_pkg::MODE_OFF :
                  nsl_pkg::MODE_GROUP;
  assign pnt_ns =
    (st_q.dup_ip || !st_q.io_conn) ? nsl_pkg::MODE_OFF :
    st_q.io_run ? nsl_pkg::MODE_GREEN : nsl_pkg::MODE_FLASH_G;
  assign proto_ns = (proto_q == nsl_pkg::PROTO_MBT) ? mbt_ns :
                    (proto_q == nsl_pkg::PROTO_PNT) ? pnt_ns : eip_ns;
  assign ns_mode_d =
    !st_q.selftest_done ? nsl_pkg::MODE_ALT :
    st_q.addr_changed ? nsl_pkg::MODE_FLASH_R :
    proto_ns;

  // --------------------------------------------------------------------------
  // Connection count flash groups
  // --------------------------------------------------------------------------
  assign grp_run = (ns_mode_d == nsl_pkg::MODE_GROUP);

  always_comb begin
    grp_d = grp_q;
    fl_d = fl_q;
    pz_d = pz_q;
    if (!grp_run) begin
      grp_d = nsl_pkg::GRP_PAUSE;
      fl_d = '0;
      pz_d = '0;
    end else if (tick) begin
      case (grp_q)
        nsl_pkg::GRP_ON: begin
          grp_d = nsl_pkg::GRP_OFF;
          fl_d = fl_q + 3'h1;
        end
        nsl_pkg::GRP_OFF: begin
          if (fl_q >= conn_n) begin
            grp_d = nsl_pkg::GRP_PAUSE;
            pz_d = '0;
          end else begin
            grp_d = nsl_pkg::GRP_ON;
          end
        end
        nsl_pkg::GRP_PAUSE: begin
          if (pz_q == 3'(nsl_pkg::PAUSE_TICKS - 1)) begin
            grp_d = nsl_pkg::GRP_ON;
            fl_d = '0;
          end else begin
            pz_d = pz_q + 3'h1;
          end
        end
        default: grp_d = nsl_pkg::GRP_PAUSE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Lamp outputs
  // --------------------------------------------------------------------------
  // Drive from the function so red and green can never overlap
  assign ms_lamp = lamp_drive(ms_mode_d, phase, 1'b0);
  assign ns_lamp = lamp_drive(ns_mode_d, phase, grp_q == nsl_pkg::GRP_ON);

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      grp_q <= nsl_pkg::GRP_PAUSE;
      fl_q <= '0;
      pz_q <= '0;
      ms_mode_q <= nsl_pkg::MODE_OFF;
      ns_mode_q <= nsl_pkg::MODE_OFF;
      {MS_RED_O, MS_GREEN_O} <= 2'h0;
      {NS_RED_O, NS_GREEN_O} <= 2'h0;
    end else begin
      grp_q <= grp_d;
      fl_q <= fl_d;
      pz_q <= pz_d;
      ms_mode_q <= ms_mode_d;
      ns_mode_q <= ns_mode_d;
      {MS_RED_O, MS_GREEN_O} <= ms_lamp;
      {NS_RED_O, NS_GREEN_O} <= ns_lamp;
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RESET_I);

  sequence ready_s;
    st_q.selftest_done && !fail_q && !st_q.addr_changed && !locked_q;
  endsequence

  sequence burst_end_s;
    grp_run && tick && grp_q == nsl_pkg::GRP_OFF && fl_q >= conn_n;
  endsequence

  init_flash_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_EIP && !st_q.link_up)
    |=> ms_mode_q == nsl_pkg::MODE_FLASH_G && MS_GREEN_O == $past(phase))
    else $error("module lamp not flashing green before link");

  run_steady_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_MBT && st_q.link_up &&
                 st_q.drive_ok && st_q.net_ok)
    |=> MS_GREEN_O && !MS_RED_O)
    else $error("module lamp not steady green when operational");

  lock_hold_a: assert property (
    locked_q && WR_I && ADDR_I == nsl_pkg::CONFIG_ADDR |=> $stable(proto_q) && locked_q)
    else $error("command accepted after flash write");

  fail_red_a: assert property (
    st_q.selftest_done && fail_q |=> ms_mode_q == nsl_pkg::MODE_FLASH_R && !MS_GREEN_O)
    else $error("flash failure not shown red");

  name_init_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_PNT && !(st_q.name_set && st_q.ip_set))
    |=> ms_mode_q == nsl_pkg::MODE_FLASH_G)
    else $error("missing name not shown as initializing");

  mbt_off_a: assert property (
    st_q.selftest_done && !st_q.addr_changed && proto_q == nsl_pkg::PROTO_MBT &&
    st_q.conn_count == 3'h0 |=> !NS_GREEN_O && !NS_RED_O)
    else $error("link lamp lit without connections");

  group_pause_a: assert property (
    burst_end_s |=> grp_q == nsl_pkg::GRP_PAUSE ##1 (!NS_GREEN_O || !grp_run))
    else $error("flash group not followed by pause");

  eip_steady_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_EIP && !st_q.dup_ip &&
                 !st_q.conn_timeout && st_q.implicit_conn)
    |=> ns_mode_q == nsl_pkg::MODE_GREEN)
    else $error("link lamp not steady with connections");

  timeout_red_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_EIP && !st_q.dup_ip &&
                 st_q.conn_timeout && ms_mode_d == nsl_pkg::MODE_GREEN)
    |=> ns_mode_q == nsl_pkg::MODE_FLASH_R)
    else $error("timeout not shown red flashing");

  dup_red_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_EIP && st_q.dup_ip)
    |=> NS_RED_O && !NS_GREEN_O)
    else $error("duplicate address not steady red");

  io_run_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_PNT && !st_q.dup_ip &&
                 st_q.io_conn && st_q.io_run)
    |=> ns_mode_q == nsl_pkg::MODE_GREEN)
    else $error("controller run not steady green");

  selftest_alt_a: assert property (
    // Release edge left out: lamps still hold their reset levels there
    !RESET_I && !st_q.selftest_done ##1 !st_q.selftest_done
    |-> MS_RED_O == $past(phase) && MS_GREEN_O == !$past(phase) && NS_RED_O == MS_RED_O)
    else $error("self-test not alternating");

  no_overlap_a: assert property (
    !(MS_RED_O && MS_GREEN_O) && !(NS_RED_O && NS_GREEN_O))
    else $error("both colours lit");

  reset_dark_a: assert property (
    @(posedge CLOCK_I) disable iff (1'b0)
    RESET_I |=> !MS_RED_O && !MS_GREEN_O && !NS_RED_O && !NS_GREEN_O)
    else $error("lamp lit after reset");

  // Address change must show on both lamps at once
  addr_flash_a: assert property (
    st_q.selftest_done && st_q.addr_changed
    |=> ms_mode_q == nsl_pkg::MODE_FLASH_R && ns_mode_q == nsl_pkg::MODE_FLASH_R)
    else $error("address change not flashing red on both lamps");

  lock_show_a: assert property (
    st_q.selftest_done && locked_q && !fail_q && !st_q.addr_changed
    |=> ms_mode_q == nsl_pkg::MODE_FLASH_G)
    else $error("flash lock not shown on module lamp");

  mbt_nolink_a: assert property (
    st_q.selftest_done && !st_q.addr_changed && proto_q == nsl_pkg::PROTO_MBT &&
    !st_q.link_up |=> ns_mode_q == nsl_pkg::MODE_OFF)
    else $error("link lamp lit without network");

  mbt_group_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_MBT && st_q.link_up &&
                 st_q.conn_count != 3'h0)
    |=> ns_mode_q == nsl_pkg::MODE_GROUP)
    else $error("connection groups not shown");

  eip_link_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_EIP && !st_q.dup_ip && !st_q.conn_timeout &&
                 !st_q.implicit_conn && st_q.link_up)
    |=> ns_mode_q == nsl_pkg::MODE_FLASH_G && NS_GREEN_O == $past(phase))
    else $error("link lamp not flashing green on bare link");

  // Red flash must follow the shared pacing phase
  red_flash_a: assert property (
    ns_mode_q == nsl_pkg::MODE_FLASH_R |-> NS_RED_O == $past(phase) && !NS_GREEN_O)
    else $error("link lamp red flash out of step");

  pnt_stop_a: assert property (
    ready_s ##0 (proto_q == nsl_pkg::PROTO_PNT && !st_q.dup_ip &&
                 st_q.io_conn && !st_q.io_run)
    |=> ns_mode_q == nsl_pkg::MODE_FLASH_G)
    else $error("controller stop not flashing green");

endmodule

// ### nsl_lamp_view.sv
// Operator view of one bi-colour lamp: counts green flashes per group.
// Assumes lamp levels are sampled on the system clock edge.
`timescale 1ns/100ps

module nsl_lamp_view #(
  parameter int unsigned HALF = 8
) (
  input wire logic clk_i,        // System clock
  input wire logic red_i,        // Red element
  input wire logic green_i,      // Green element
  output logic clash_o,          // Both elements were seen lit
  output logic [3:0] grp_n_o,    // Flashes in the last whole group
  output logic [15:0] groups_o   // Groups seen so far
);
  logic [7:0] dark_q;
  logic [3:0] pulses_q;
  logic green_q;

  initial begin
    clash_o = 1'b0;
    grp_n_o = 4'h0;
    groups_o = 16'h0000;
    dark_q = 8'h00;
    pulses_q = 4'h0;
    green_q = 1'b0;
  end

  always @(posedge clk_i) begin
    green_q <= green_i;
    if (red_i && green_i) clash_o <= 1'b1;
    if (green_i) dark_q <= 8'h00;
    else if (dark_q != 8'hFF) dark_q <= dark_q + 8'h01;
    if (green_i && !green_q) begin
      // A dark gap longer than three half periods ends a group
      if (dark_q > 3 * HALF && pulses_q != 4'h0) begin
        grp_n_o <= pulses_q;
        groups_o <= groups_o + 16'h0001;
        pulses_q <= 4'h1;
      end else begin
        pulses_q <= pulses_q + 4'h1;
      end
    end
  end
endmodule

// ### nsl_led_top_tb_top.sv
// Self-checking bench for the status lamp driver, register port driven.
// Assumes a shortened flash half period so groups fit in a short run.
`timescale 1ns/100ps

module nsl_led_top_tb_top;
  localparam int unsigned HALF = 8;
  logic clock_i, reset_i, wr_i, rd_i, ms_red, ms_green, ns_red, ns_green;
  logic ms_clash, ns_clash, lock_q, fail_q;
  logic [3:0] addr_i, grp_n;
  logic [31:0] wdata_i, rdata_o, got;
  logic [15:0] groups;
  logic [1:0] proto;
  logic [16:0] corners [14];
  int n_fail = 0;
  int check_count = 0;

  nsl_led_top #(.FLASH_HALF_CYCLES(HALF)) nsl_led_top_i (
    .CLOCK_I(clock_i), .RESET_I(reset_i), .ADDR_I(addr_i), .WDATA_I(wdata_i),
    .WR_I(wr_i), .RD_I(rd_i), .RDATA_O(rdata_o), .MS_RED_O(ms_red),
    .MS_GREEN_O(ms_green), .NS_RED_O(ns_red), .NS_GREEN_O(ns_green));
  nsl_lamp_view #(.HALF(HALF)) nsl_lamp_view_i (.clk_i(clock_i), .red_i(ns_red),
    .green_i(ns_green), .clash_o(ns_clash), .grp_n_o(grp_n), .groups_o(groups));
  nsl_lamp_view #(.HALF(HALF)) nsl_lamp_view_ms_i (.clk_i(clock_i), .red_i(ms_red),
    .green_i(ms_green), .clash_o(ms_clash), .grp_n_o(), .groups_o());

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  // ----------------------------------------------------------------------
  // Expected lamp modes
  // ----------------------------------------------------------------------
  function automatic logic [2:0] exp_ms(logic [1:0] p, logic [14:0] s);
    if (!s[0]) return 3'h5;
    if (fail_q || s[4]) return 3'h4;
    if (lock_q) return 3'h3;
    if (p == 2'h2) return (s[5] && s[6]) ? 3'h1 : 3'h3;
    if (!s[1]) return 3'h3;
    return (s[2] && s[3]) ? 3'h1 : 3'h3;
  endfunction

  function automatic logic [2:0] exp_ns(logic [1:0] p, logic [14:0] s, logic [2:0] m);
    if (!s[0]) return 3'h5;
    if (s[4]) return 3'h4;
    if (p == 2'h1) return (s[14:12] == 3'h0 || !s[1]) ? 3'h0 : 3'h6;
    if (p == 2'h2) return (s[9] || !s[10]) ? 3'h0 : (s[11] ? 3'h1 : 3'h3);
    if (s[9]) return 3'h2;
    if (s[8] && m == 3'h1) return 3'h4;
    if (s[7]) return 3'h1;
    return s[1] ? 3'h3 : 3'h0;
  endfunction

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic steady(input logic [2:0] m, input logic r, input logic g);
    if (m == 3'h0) check({r, g}, 2'b00);
    if (m == 3'h1) check({r, g}, 2'b01);
    if (m == 3'h2) check({r, g}, 2'b10);
  endtask

  task automatic apply(input logic [1:0] p, input logic [14:0] s);
    logic [2:0] m;
    wr(nsl_pkg::CONFIG_ADDR, {30'h0, p});
    if (!lock_q) proto = p;
    wr(nsl_pkg::STATUS_ADDR, {17'h0, s});
    repeat (3) @(posedge clock_i);
    rd(nsl_pkg::LAMP_ADDR, got);
    m = exp_ms(proto, s);
    check(got[2:0], m);
    check(got[5:3], exp_ns(proto, s, m));
    steady(m, ms_red, ms_green);
    steady(exp_ns(proto, s, m), ns_red, ns_green);
  endtask

  task automatic do_reset();
    reset_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    reset_i <= 1'b0;
    #1 check({28'h0, ms_red, ms_green, ns_red, ns_green}, 32'h0);
    check(rdata_o, 32'h0);
    lock_q = 1'b0;
    fail_q = 1'b0;
    proto = 2'h0;
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock_i);
    n_fail++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    logic [15:0] g0;
    logic [14:0] s;
    int k;
    reset_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    lock_q = 1'b0;
    fail_q = 1'b0;
    proto = 2'h0;
    corners = '{{2'h0, 15'h0000}, {2'h0, 15'h0001}, {2'h0, 15'h000F}, {2'h0, 15'h008F},
      {2'h0, 15'h010F}, {2'h0, 15'h020F}, {2'h0, 15'h0011}, {2'h1, 15'h000F},
      {2'h1, 15'h300D}, {2'h2, 15'h0061}, {2'h2, 15'h0021}, {2'h2, 15'h0461},
      {2'h2, 15'h0C61}, {2'h3, 15'h008F}};
    void'($urandom(32'h14BA));
    do_reset();
    foreach (corners[i]) apply(corners[i][16:15], corners[i][14:0]);
    $display("corner cases done");
    repeat (40) begin
      s = 15'($urandom);
      s[0] = ($urandom % 8) != 0;
      apply(2'($urandom), s);
    end
    $display("random status done");
    for (int n = 1; n <= 7; n++) begin
      apply(2'h1, {3'(n), 12'h00F});
      g0 = groups;
      k = 0;
      while (groups < g0 + 2 && k < 1000) begin
        @(posedge clock_i);
        k++;
      end
      check({31'h0, k < 1000}, 32'h1);
      check({28'h0, grp_n}, (n > 5) ? 32'h5 : 32'(n));
    end
    check({ms_clash, ns_clash}, 2'b00);
    $display("flash groups done");
    wr(nsl_pkg::FLASH_ADDR, 32'h2);
    fail_q = 1'b1;
    apply(2'h0, 15'h000F);
    rd(nsl_pkg::FLASH_ADDR, got);
    check(got[1:0], 2'h2);
    $display("flash failure done");
    @(posedge clock_i);
    do_reset();
    wr(nsl_pkg::FLASH_ADDR, 32'h1);
    lock_q = 1'b1;
    apply(2'h1, 15'h000F);
    wr(nsl_pkg::FLASH_ADDR, 32'h2);
    rd(nsl_pkg::FLASH_ADDR, got);
    check(got[1:0], 2'h1);
    rd(nsl_pkg::CONFIG_ADDR, got);
    check(got[1:0], 2'h0);
    rd(4'h2, got);
    check(got, 32'h0);
    $display("flash lock done");
    complete_run();
  end
endmodule
